// *** common/reset_seq_regs.svh ***
// Purpose: Constants for the reset source sequencer
// Assumes: 40 MHz core clock
// Notes: Flag bit positions follow the reset control register layout
`ifndef RESET_SEQ_REGS_SVH
`define RESET_SEQ_REGS_SVH
`define POR_FLAG_BIT 1
`define BOR_FLAG_BIT 0
`define CM_FLAG_BIT 5
`define PUT_WIDTH 11
`define PUT_TICKS 2048
`define PUT_TICK_NS 32000
`define CLK_PERIOD_NS 25
`define PUT_TICK_CYCLES (`PUT_TICK_NS / `CLK_PERIOD_NS)
`define PIN_FILTER_CYCLES 8
`define FLAG_RESET_VAL 8'h00
`endif

// *** common/reset_seq_pkg.sv ***
// Purpose: Types for the reset source sequencer
// Assumes: Nothing
// Notes: Timing constants live in the regs header
package reset_seq_pkg;
    typedef enum logic [1:0] {SEQ_POWER, SEQ_HOLD, SEQ_TIMING, SEQ_RUN} seq_state_t;
endpackage

// *** common/tick_if.sv ***
// Purpose: Carries the timer tick and pin filter result between modules
// Assumes: Single clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ps
interface tick_if;
    logic tick;
    logic pin_low;
    modport src (output tick, output pin_low);
    modport dst (input tick, input pin_low);
endinterface

// *** logic/rc_tick_filter.sv ***
// Purpose: Internal RC tick divider and reset pin filter
// Assumes: Pin already synchronised by the caller
// Notes: Filter counts on core cycles
`timescale 1ns/1ps
`include "reset_seq_regs.svh"
module rc_tick_filter #(
    parameter int TICK_CYCLES = `PUT_TICK_CYCLES,
    parameter int FILTER_CYCLES = `PIN_FILTER_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_sync_n_in,
    tick_if.src tk
);
    logic [15:0] div_q;
    logic [7:0] flt_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q <= 16'h0000;
            tk.tick <= 1'b0;
        end else if (div_q == 16'(TICK_CYCLES - 1)) begin
            div_q <= 16'h0000;
            tk.tick <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            tk.tick <= 1'b0;
        end
    end
    // Low accepted only after a stable run; a high releases at once
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flt_q <= 8'h00;
            tk.pin_low <= 1'b0;
        end else if (pin_sync_n_in) begin
            flt_q <= 8'h00;
            tk.pin_low <= 1'b0;
        end else if (flt_q == 8'(FILTER_CYCLES - 1)) begin
            tk.pin_low <= 1'b1;
        end else begin
            flt_q <= flt_q + 8'h01;
        end
    end
endmodule // rc_tick_filter

// *** logic/put_counter.sv ***
// Purpose: Power-up timer counter
// Assumes: Tick from the internal RC divider
// Notes: Restarts whenever clear is high
`timescale 1ns/1ps
`include "reset_seq_regs.svh"
module put_counter #(
    parameter int WIDTH = `PUT_WIDTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    tick_if.dst tk,
    output logic done_out
);
    logic [WIDTH:0] cnt_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (clear_in) begin
            cnt_q <= '0;
        end else if (tk.tick && !cnt_q[WIDTH]) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign done_out = cnt_q[WIDTH];
endmodule // put_counter

// *** logic/reset_source_sequencer.sv ***
// Purpose: Combine reset sources, run the power-up timer, keep cause flags
// Assumes: Supply monitors are asynchronous levels, synchronised here
// Notes: Flags are active low and set to one by software strobes
`timescale 1ns/1ps
`include "reset_seq_regs.svh"
module reset_source_sequencer
    import reset_seq_pkg::*;
#(
    parameter int CFG_WIDTH = 16,
    parameter int FILTER_CYCLES = `PIN_FILTER_CYCLES,
    parameter int TICK_CYCLES = `PUT_TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic external_reset_pin_n_in,
    input wire logic supply_good_in,
    input wire logic regulator_enable_pin_in,
    input wire logic regulator_ok_in,
    input wire logic [CFG_WIDTH-1:0] config_in,
    input wire logic [CFG_WIDTH-1:0] config_shadow_n_in,
    input wire logic soft_reset_in,
    input wire logic set_por_flag_in,
    input wire logic set_bor_flag_in,
    input wire logic set_cm_flag_in,
    output logic core_reset_n_out,
    output logic config_reload_out,
    output logic por_flag_n_out,
    output logic brownout_flag_n_out,
    output logic config_mismatch_flag_n_out,
    output logic pin_drive_out,
    output logic pin_oe_out
);
    logic [1:0] pin_s_q, sup_s_q, ven_s_q, rok_s_q;
    logic sup_prev_q, por_pulse_q, bor_q, cm_q, put_clear;
    logic put_done, hold, rel1_q, rel2_q;
    seq_state_t state_q;
    tick_if tk();

    // Two-stage synchronisers; stage zero read only by stage one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s_q <= 2'h0;
            sup_s_q <= 2'h0;
            ven_s_q <= 2'h0;
            rok_s_q <= 2'h0;
        end else begin
            pin_s_q <= {pin_s_q[0], external_reset_pin_n_in};
            sup_s_q <= {sup_s_q[0], supply_good_in};
            ven_s_q <= {ven_s_q[0], regulator_enable_pin_in};
            rok_s_q <= {rok_s_q[0], regulator_ok_in};
        end
    end

    rc_tick_filter #(.TICK_CYCLES(TICK_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) u_filter (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_sync_n_in(pin_s_q[1]),
        .tk(tk.src)
    );

    // Power-on pulse: one cycle per supply-good rise, or held while supply is bad
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sup_prev_q <= 1'b0;
            por_pulse_q <= 1'b1;
        end else begin
            sup_prev_q <= sup_s_q[1];
            por_pulse_q <= !sup_s_q[1] || (sup_s_q[1] && !sup_prev_q);
        end
    end

    always_comb begin
        bor_q = ven_s_q[1] && !rok_s_q[1];
        cm_q = (config_in != ~config_shadow_n_in);
        put_clear = por_pulse_q || bor_q;
    end

    put_counter #(.WIDTH(`PUT_WIDTH)) u_put (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(put_clear),
        .tk(tk.dst),
        .done_out(put_done)
    );

    // Pin and mismatch only gate release; timer runs from power-on regardless
    assign hold = put_clear || !put_done || tk.pin_low || cm_q || soft_reset_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= SEQ_POWER;
        end else begin
            unique case (state_q)
                SEQ_POWER: if (!put_clear) state_q <= SEQ_TIMING;
                SEQ_TIMING: begin
                    if (put_clear) state_q <= SEQ_POWER;
                    else if (put_done) state_q <= SEQ_HOLD;
                end
                SEQ_HOLD: begin
                    if (put_clear) state_q <= SEQ_POWER;
                    else if (!hold) state_q <= SEQ_RUN;
                end
                SEQ_RUN: begin
                    if (put_clear) state_q <= SEQ_POWER;
                    else if (hold) state_q <= SEQ_HOLD;
                end
            endcase
        end
    end

    // Asynchronous assert on the global reset, three-flop synchronous release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rel1_q <= 1'b0;
            rel2_q <= 1'b0;
            core_reset_n_out <= 1'b0;
        end else begin
            rel1_q <= !hold;
            rel2_q <= rel1_q && !hold;
            core_reset_n_out <= rel2_q && !hold;
        end
    end

    // Reload pulse on the first cycle of any reset after release, soft included; none on the global reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_reload_out <= 1'b0;
        end else begin
            config_reload_out <= hold && core_reset_n_out;
        end
    end

    // Hardware clear wins over a software set in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            por_flag_n_out <= 1'b0;
        end else if (por_pulse_q) begin
            por_flag_n_out <= 1'b0;
        end else if (set_por_flag_in) begin
            por_flag_n_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brownout_flag_n_out <= 1'b0;
        end else if (por_pulse_q || bor_q) begin
            brownout_flag_n_out <= 1'b0;
        end else if (set_bor_flag_in) begin
            brownout_flag_n_out <= 1'b1;
        end
    end

    // Mismatch flag is not cleared by the power-on pulse; the global reset loads it to one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_mismatch_flag_n_out <= 1'b1;
        end else if (cm_q) begin
            config_mismatch_flag_n_out <= 1'b0;
        end else if (set_cm_flag_in) begin
            config_mismatch_flag_n_out <= 1'b1;
        end
    end

    // Pin is input only: never driven
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_drive_out <= 1'b1;
            pin_oe_out <= 1'b0;
        end else begin
            pin_drive_out <= 1'b1;
            pin_oe_out <= 1'b0;
        end
    end
endmodule // reset_source_sequencer

// *** test/reset_source_sequencer_monitor.sv ***
// Purpose: Port assertions for the reset source sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes: Windows allow for the two-flop input synchronisers
`timescale 1ns/1ps
module reset_seq_monitor #(
    parameter int CFG_WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic external_reset_pin_n_in,
    input wire logic supply_good_in,
    input wire logic regulator_enable_pin_in,
    input wire logic regulator_ok_in,
    input wire logic [CFG_WIDTH-1:0] config_in,
    input wire logic [CFG_WIDTH-1:0] config_shadow_n_in,
    input wire logic soft_reset_in,
    input wire logic set_por_flag_in,
    input wire logic set_bor_flag_in,
    input wire logic set_cm_flag_in,
    input wire logic core_reset_n_out,
    input wire logic config_reload_out,
    input wire logic por_flag_n_out,
    input wire logic brownout_flag_n_out,
    input wire logic config_mismatch_flag_n_out,
    input wire logic pin_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic mism;
    assign mism = config_in != ~config_shadow_n_in;
    a_pin_not_driven: assert property (!pin_oe_out) else $error("reset pin driven");
    a_por_soft_set: assert property ($rose(por_flag_n_out) |-> $past(set_por_flag_in)) else $error("por set");
    a_bor_soft_set: assert property ($rose(brownout_flag_n_out) |-> $past(set_bor_flag_in)) else $error("bor set");
    a_cm_soft_set: assert property ($rose(config_mismatch_flag_n_out) |-> $past(set_cm_flag_in)) else $error("cm set");
    a_supply_low_hold: assert property ((!supply_good_in)[*5] |-> !por_flag_n_out && !brownout_flag_n_out
        && !core_reset_n_out) else $error("supply low not held");
    a_brownout_hold: assert property ((regulator_enable_pin_in && !regulator_ok_in)[*5]
        |-> !brownout_flag_n_out && !core_reset_n_out) else $error("brown-out not held");
    a_bor_disabled: assert property ((!regulator_enable_pin_in && supply_good_in)[*8]
        |-> !$fell(brownout_flag_n_out)) else $error("bor flag fell with regulator off");
    a_pin_low_reset: assert property ((!external_reset_pin_n_in)[*8] ##1 (!external_reset_pin_n_in)[*6]
        |-> !core_reset_n_out) else $error("pin low without reset");
    a_cm_flag_clear: assert property (mism |-> ##[1:2] !config_mismatch_flag_n_out) else $error("cm flag");
    a_cm_reset: assert property (mism |-> ##1 !core_reset_n_out) else $error("no mismatch reset");
    a_soft_reset: assert property (soft_reset_in |-> ##1 !core_reset_n_out) else $error("no soft reset");
    a_reload_pulse: assert property (config_reload_out |=> !config_reload_out && !core_reset_n_out)
        else $error("reload pulse");
endmodule // reset_seq_monitor
bind reset_source_sequencer reset_seq_monitor #(.CFG_WIDTH(CFG_WIDTH)) u_mon (.clk_in, .rst_n_in,
    .external_reset_pin_n_in, .supply_good_in, .regulator_enable_pin_in, .regulator_ok_in, .config_in,
    .config_shadow_n_in, .soft_reset_in, .set_por_flag_in, .set_bor_flag_in, .set_cm_flag_in, .core_reset_n_out,
    .config_reload_out, .por_flag_n_out, .brownout_flag_n_out, .config_mismatch_flag_n_out, .pin_oe_out);

// *** test/supply_pin_model.sv ***
// Purpose: Board reset pin with pull-up and supply monitors
// Assumes: Caller changes levels just after a clock edge
// Notes: Control word is pin low, supply good, regulator on, regulator ok
`timescale 1ns/1ps
module supply_pin_model (
    input wire logic pin_oe_in,
    input wire logic pin_drive_in,
    output logic pin_n_out,
    output logic supply_good_out,
    output logic reg_en_out,
    output logic reg_ok_out
);
    logic pull_low;
    // Pull-up gives the level whenever no party pulls the pin
    assign pin_n_out = pin_oe_in ? pin_drive_in : !pull_low;
    task automatic drive(input logic [3:0] v);
        {pull_low, supply_good_out, reg_en_out, reg_ok_out} = v;
    endtask
    initial begin
        drive(4'h2);
    end
endmodule // supply_pin_model

// *** test/reset_source_sequencer_tb_top.sv ***
// Purpose: Directed tests for the reset source sequencer
// Assumes: Timer tick shortened to two core cycles
// Notes: Flag triplet order is power-on, brown-out, mismatch
`timescale 1ns/1ps
module reset_source_sequencer_tb_top;
    logic clk_in, rst_n_in, pin_n, good, reg_en, reg_ok, soft_rst, set_por, set_bor, set_cm;
    logic [15:0] cfg, shadow_n;
    logic core_n, reload, por_n, bor_n, cm_n, pdrv, poe;
    int err_total = 0;
    int checks_done = 0;
    int n;
    initial begin
        clk_in = 1'h0;
        forever #12.5 clk_in = ~clk_in;
    end
    reset_source_sequencer #(.TICK_CYCLES(2)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .external_reset_pin_n_in(pin_n), .supply_good_in(good), .regulator_enable_pin_in(reg_en),
        .regulator_ok_in(reg_ok), .config_in(cfg), .config_shadow_n_in(shadow_n), .soft_reset_in(soft_rst),
        .set_por_flag_in(set_por), .set_bor_flag_in(set_bor), .set_cm_flag_in(set_cm), .core_reset_n_out(core_n),
        .config_reload_out(reload), .por_flag_n_out(por_n), .brownout_flag_n_out(bor_n),
        .config_mismatch_flag_n_out(cm_n), .pin_drive_out(pdrv), .pin_oe_out(poe));
    supply_pin_model u_model (.pin_oe_in(poe), .pin_drive_in(pdrv), .pin_n_out(pin_n), .supply_good_out(good),
        .reg_en_out(reg_en), .reg_ok_out(reg_ok));
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #2;
    endtask
    task automatic chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic flags(input logic [2:0] exp);
        chk(por_n, exp[2]);
        chk(bor_n, exp[1]);
        chk(cm_n, exp[0]);
    endtask
    task automatic stay(input int k, input logic v);
        repeat (k) begin
            cyc(1);
            chk(core_n, v);
        end
    endtask
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (core_n !== 1'h1 && n < hi) begin
            cyc(1);
            n++;
        end
        chk(n >= lo && n < hi, 1'h1);
    endtask
    // Software sets all three flags back to one
    task automatic set_flags;
        {set_por, set_bor, set_cm} = 3'h7;
        cyc(1);
        {set_por, set_bor, set_cm} = 3'h0;
        cyc(1);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40000 * 25);
        err_total++;
        summarize();
    end
    initial begin
        {rst_n_in, soft_rst, set_por, set_bor, set_cm} = 5'h0;
        cfg = 16'h5a3c;
        shadow_n = ~16'h5a3c;
        cyc(3);
        rst_n_in = 1'h1;
        flags(3'h1);
        u_model.drive(4'h7);
        wait_run(4090, 4200);
        flags(3'h1);
        set_flags();
        flags(3'h7);
        u_model.drive(4'hf);
        cyc(5);
        u_model.drive(4'h7);
        stay(16, 1'h1);
        u_model.drive(4'hf);
        cyc(20);
        chk(core_n, 1'h0);
        u_model.drive(4'h7);
        wait_run(1, 10);
        soft_rst = 1'h1;
        cyc(1);
        soft_rst = 1'h0;
        chk(core_n, 1'h0);
        chk(reload, 1'h1);
        chk(poe, 1'h0);
        chk(pdrv, 1'h1);
        wait_run(1, 10);
        chk(reload, 1'h0);
        flags(3'h7);
        // New config word with a matching shadow must not reset
        cfg = 16'ha5c3;
        shadow_n = ~16'ha5c3;
        stay(4, 1'h1);
        flags(3'h7);
        shadow_n = ~cfg ^ 16'h0100;
        cyc(3);
        chk(core_n, 1'h0);
        flags(3'h6);
        shadow_n = ~cfg;
        wait_run(1, 10);
        set_flags();
        u_model.drive(4'h6);
        cyc(6);
        chk(core_n, 1'h0);
        flags(3'h5);
        u_model.drive(4'h7);
        stay(2000, 1'h0);
        u_model.drive(4'h6);
        cyc(6);
        u_model.drive(4'h7);
        wait_run(4090, 4200);
        set_flags();
        u_model.drive(4'h4);
        stay(20, 1'h1);
        flags(3'h7);
        u_model.drive(4'h8);
        cyc(6);
        flags(3'h1);
        u_model.drive(4'hc);
        cyc(4300);
        chk(core_n, 1'h0);
        u_model.drive(4'h4);
        wait_run(1, 8);
        // Global reset again mid-run: flags to reset values, timer restarts
        rst_n_in = 1'h0;
        cyc(1);
        chk(core_n, 1'h0);
        chk(reload, 1'h0);
        flags(3'h1);
        rst_n_in = 1'h1;
        stay(2, 1'h0);
        summarize();
    end
endmodule // reset_source_sequencer_tb_top
